// ==== src/adcsr_pkg.sv ====
// constants shared by the serial register decode block
package adcsr_pkg;

	// ---------------------------------------------------------------
	// word layout
	// ---------------------------------------------------------------
	localparam int WORD_W   = 16;
	localparam int DATA_W   = 14;
	localparam int TGT_HI   = 15;
	localparam int TGT_LO   = 14;
	localparam int CNT_W    = 5;
	localparam logic [CNT_W-1:0] LAST_BIT = 5'h0F;

	// ---------------------------------------------------------------
	// write targets and read sources
	// ---------------------------------------------------------------
	localparam logic [1:0] TGT_NONE  = 2'h0;
	localparam logic [1:0] TGT_TEST  = 2'h1;
	localparam logic [1:0] TGT_CAL   = 2'h2;
	localparam logic [1:0] TGT_CTRL  = 2'h3;
	localparam logic [1:0] RD_RESULT = 2'h0;
	localparam logic [1:0] RD_TEST   = 2'h1;
	localparam logic [1:0] RD_CAL    = 2'h2;
	localparam logic [1:0] RD_STATUS = 2'h3;

	// ---------------------------------------------------------------
	// conversion_control fields and status word
	// ---------------------------------------------------------------
	localparam int CTL_PD_HI  = 9;
	localparam int CTL_PD_LO  = 8;
	localparam int CTL_RS_HI  = 7;
	localparam int CTL_RS_LO  = 6;
	localparam int CTL_MODE   = 5;
	localparam int CTL_CONV   = 4;
	localparam int CTL_CALSYS = 3;
	localparam int CTL_CS_HI  = 2;
	localparam int CTL_CS_LO  = 1;
	localparam int CTL_CALGO  = 0;
	localparam logic [DATA_W-1:0] CTL_RESET = 14'h0000;
	localparam logic [1:0] LEAD_ZERO = 2'h0;
	localparam logic [3:0] ST_ZERO4  = 4'h0;

	// calibration step mask: bit 2 dac, bit 1 gain, bit 0 offset
	function automatic logic [2:0] cal_steps_of(input logic [1:0] sel);
		unique case (sel)
			2'h0: cal_steps_of = 3'h7;
			2'h1: cal_steps_of = 3'h3;
			2'h2: cal_steps_of = 3'h1;
			2'h3: cal_steps_of = 3'h2;
		endcase
	endfunction

endpackage

// ==== src/adcsr_link_if.sv ====
// word-level carrier between the serial shifter and the register decode
`timescale 1ns/1ps
interface adcsr_link_if;
	logic        word_valid; // one-cycle pulse, full write word taken
	logic [15:0] word;       // assembled write word
	logic        read_done;  // one-cycle pulse, full read frame sent
	logic [15:0] rd_word;    // word to send in the next frame
	logic        mode1;      // send read data on the input pin

	modport shifter (output word_valid, output word, output read_done,
		input rd_word, input mode1);
	modport decoder (input word_valid, input word, input read_done,
		output rd_word, output mode1);
endinterface

// ==== src/adcsr_shift.sv ====
// serial shifter: samples the serial pins and assembles 16-bit frames
`timescale 1ns/1ps
module adcsr_shift
(
	// clock and reset
	input  wire logic         core_clk,
	input  wire logic         resetn,
	// serial pins
	input  wire logic         sclk,
	input  wire logic         sync_n,
	input  wire logic         din,
	output logic              dout,
	output logic              din_out,
	output logic              din_oe,
	// word side
	adcsr_link_if.shifter     lk
);
	logic                       sclk_s1, sclk_s2, sclk_q;
	logic                       sync_s1, sync_s2, frame_q;
	logic                       din_s1, din_s2;
	logic [adcsr_pkg::CNT_W-1:0] cnt;
	logic [15:0]                in_sr, out_sr;
	logic                       drive_din;
	wire                        frame = ~sync_s2;
	wire                        rise  = sclk_s2 & ~sclk_q;
	wire                        fall  = ~sclk_s2 & sclk_q;
	wire                        last  = rise && frame && cnt == adcsr_pkg::LAST_BIT;

	// -----------------------------------------------------------------
	// pin synchronisers, third stage only for edge finding
	// -----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			{sclk_s1, sclk_s2, sclk_q} <= 3'h0;
			{sync_s1, sync_s2, frame_q} <= 3'h6;
			{din_s1, din_s2} <= 2'h0;
		end
		else
		begin
			{sclk_s1, sclk_s2, sclk_q} <= {sclk, sclk_s1, sclk_s2};
			{sync_s1, sync_s2, frame_q} <= {sync_n, sync_s1, frame};
			{din_s1, din_s2} <= {din, din_s1};
		end
	end

	// input side: msb first, a word counts only once 16 bits are in
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cnt <= '0;
			in_sr <= '0;
			lk.word_valid <= 1'b0;
			lk.read_done <= 1'b0;
			lk.word <= '0;
		end
		else
		begin
			lk.word_valid <= last && !drive_din;
			lk.read_done <= last;
			if (frame && !frame_q)
				cnt <= '0; // a short frame is simply forgotten
			else if (rise && frame && cnt <= adcsr_pkg::LAST_BIT)
			begin
				in_sr <= {in_sr[14:0], din_s2};
				cnt <= cnt + 5'h01;
			end
			if (last)
				lk.word <= {in_sr[14:0], din_s2};
		end
	end

	// output side: first bit shows at frame start, next on each fall
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			out_sr <= '0;
			dout <= 1'b0;
			din_out <= 1'b0;
			din_oe <= 1'b0;
			drive_din <= 1'b0;
		end
		else
		begin
			if (frame && !frame_q)
			begin
				out_sr <= lk.rd_word;
				dout <= lk.rd_word[15];
				din_out <= lk.rd_word[15];
				drive_din <= lk.mode1; // frame turns the input pin around
			end
			else if (fall && frame)
			begin
				out_sr <= {out_sr[14:0], 1'b0};
				dout <= out_sr[14];
				din_out <= out_sr[14];
			end
			din_oe <= frame && (frame_q ? drive_din : lk.mode1);
		end
	end

	// -----------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	mode1_no_write_a: assert property (lk.word_valid |-> !drive_din)
		else $error("write word taken in a frame that drives the input pin");
	full_word_a: assert property (lk.word_valid |-> $past(cnt) == 5'h0F)
		else $error("write word emitted before sixteen bits");
	read_cov: cover property (lk.read_done && drive_din);

endmodule // adcsr_shift

// ==== src/adcsr_top.sv ====
// serial register decode for a calibrating converter: write decode, control, read mux
`timescale 1ns/1ps
module adcsr_top
(
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        resetn,
	// serial pins
	input  wire logic        sclk,
	input  wire logic        sync_n,
	input  wire logic        din,
	output logic             dout,
	output logic             din_out,
	output logic             din_oe,
	// power-down pin
	input  wire logic        sleep_n,
	// conversion and calibration engine
	input  wire logic        conv_done,
	input  wire logic        cal_done,
	input  wire logic [13:0] conv_result,
	input  wire logic [13:0] cal_rd_data,
	output logic             conv_start,
	output logic             cal_go,
	output logic             cal_system,
	output logic [2:0]       cal_steps,
	output logic [1:0]       cal_sel,
	output logic             cal_wr_en,
	output logic [13:0]      cal_wr_data,
	// mode outputs
	output logic [2:0]       power_state,
	output logic             serial_mode1
);
	// -----------------------------------------------------------------
	// declarations
	// -----------------------------------------------------------------
	adcsr_link_if lk ();

	logic [13:0] conversion_control;
	logic [13:0] test_reg;
	logic        sleep_s1, sleep_s2;
	logic [15:0] next_rd_word;
	logic [1:0]  tgt;
	logic [1:0]  rsel;
	logic        wr_test, wr_cal, wr_ctrl;
	logic [13:0] wdata;

	// word target decode on the full word only; address 00 raises no strobe
	assign tgt     = lk.word[adcsr_pkg::TGT_HI:adcsr_pkg::TGT_LO];
	assign wdata   = lk.word[adcsr_pkg::DATA_W-1:0];
	assign wr_test = lk.word_valid && tgt == adcsr_pkg::TGT_TEST;
	assign wr_cal  = lk.word_valid && tgt == adcsr_pkg::TGT_CAL;
	assign wr_ctrl = lk.word_valid && tgt == adcsr_pkg::TGT_CTRL;
	assign rsel    = conversion_control[adcsr_pkg::CTL_RS_HI:adcsr_pkg::CTL_RS_LO];

	// -----------------------------------------------------------------
	// serial shifter
	// -----------------------------------------------------------------
	adcsr_shift u_shift
	(
		.core_clk (core_clk),
		.resetn   (resetn),
		.sclk     (sclk),
		.sync_n   (sync_n),
		.din      (din),
		.dout     (dout),
		.din_out  (din_out),
		.din_oe   (din_oe),
		.lk       (lk)
	);

	// -----------------------------------------------------------------
	// control register
	// -----------------------------------------------------------------
	// a write wins over any self-clear arriving in the same cycle,
	// so a write that sets the mode bit survives the read_done of its own frame
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			conversion_control <= adcsr_pkg::CTL_RESET;
		else if (wr_ctrl)
			conversion_control <= wdata; // bits 13:10 kept as sent
		else
		begin
			if (lk.read_done)
				conversion_control[adcsr_pkg::CTL_MODE] <= 1'b0;
			if (conv_done)
				conversion_control[adcsr_pkg::CTL_CONV] <= 1'b0;
			if (cal_done)
				conversion_control[adcsr_pkg::CTL_CALGO] <= 1'b0;
		end
	end

	// test register, written only by address 01
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			test_reg <= '0;
		else if (wr_test)
			test_reg <= wdata;
	end

	// calibration coefficient write, addressed by the select bits
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cal_wr_en <= 1'b0;
			cal_wr_data <= '0;
		end
		else
		begin
			cal_wr_en <= wr_cal;
			if (wr_cal)
				cal_wr_data <= wdata;
		end
	end

	// -----------------------------------------------------------------
	// start pulses and calibration type
	// -----------------------------------------------------------------
	// starts fire from the written word so they are one cycle long
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			conv_start <= 1'b0;
			cal_go <= 1'b0;
			cal_system <= 1'b0;
			cal_steps <= '0;
		end
		else
		begin
			conv_start <= wr_ctrl && wdata[adcsr_pkg::CTL_CONV];
			cal_go <= wr_ctrl && wdata[adcsr_pkg::CTL_CALGO];
			if (wr_ctrl && wdata[adcsr_pkg::CTL_CALGO])
			begin
				cal_system <= wdata[adcsr_pkg::CTL_CALSYS];
				cal_steps <= adcsr_pkg::cal_steps_of(
					wdata[adcsr_pkg::CTL_CS_HI:adcsr_pkg::CTL_CS_LO]);
			end
		end
	end

	// select bits double as coefficient address while idle
	assign cal_sel = conversion_control[adcsr_pkg::CTL_CS_HI:adcsr_pkg::CTL_CS_LO];
	assign serial_mode1 = conversion_control[adcsr_pkg::CTL_MODE];
	assign lk.mode1 = conversion_control[adcsr_pkg::CTL_MODE];

	// -----------------------------------------------------------------
	// power-down selection
	// -----------------------------------------------------------------
	// sleep pin is asynchronous, two stages before use
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			{sleep_s1, sleep_s2} <= 2'h3;
			power_state <= '0;
		end
		else
		begin
			{sleep_s1, sleep_s2} <= {sleep_n, sleep_s1};
			power_state <= {~sleep_s2, conversion_control[adcsr_pkg::CTL_PD_HI],
				conversion_control[adcsr_pkg::CTL_PD_LO]};
		end
	end

	// -----------------------------------------------------------------
	// read source
	// -----------------------------------------------------------------
	// the frame loads this word at its start, so a source change
	// only affects frames that begin afterwards
	always_comb
	begin
		unique case (rsel)
			adcsr_pkg::RD_RESULT: next_rd_word = {adcsr_pkg::LEAD_ZERO, conv_result};
			adcsr_pkg::RD_TEST:   next_rd_word = {adcsr_pkg::LEAD_ZERO, test_reg};
			adcsr_pkg::RD_CAL:    next_rd_word = {adcsr_pkg::LEAD_ZERO, cal_rd_data};
			adcsr_pkg::RD_STATUS: next_rd_word = {1'b0,
				conversion_control[adcsr_pkg::CTL_CONV] | conversion_control[adcsr_pkg::CTL_CALGO],
				adcsr_pkg::ST_ZERO4, conversion_control[9:5], 1'b0, conversion_control[3:0]};
		endcase
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			lk.rd_word <= '0;
		else
			lk.rd_word <= next_rd_word;
	end

	// -----------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	no_target_a: assert property (lk.word_valid && tgt == adcsr_pkg::TGT_NONE
		&& !conv_done && !cal_done |=> !cal_wr_en && $stable(test_reg)
		&& {conversion_control[13:6], conversion_control[4:0]}
		== $past({conversion_control[13:6], conversion_control[4:0]}))
		else $error("address 00 word changed a register");

	test_write_a: assert property (wr_test |=> test_reg == $past(wdata))
		else $error("test register missed its write");

	test_hold_a: assert property (!wr_test |=> $stable(test_reg))
		else $error("test register changed without a full word");

	cal_write_a: assert property (wr_cal |=> cal_wr_en && cal_wr_data == $past(wdata))
		else $error("calibration write not issued");

	ctrl_write_a: assert property (wr_ctrl |=> conversion_control == $past(wdata))
		else $error("control register missed its write");

	mode_clear_a: assert property (lk.read_done && !wr_ctrl |=> !serial_mode1)
		else $error("mode bit survived a read frame");

	conv_pulse_a: assert property (wr_ctrl && wdata[4] |=> conv_start ##1 !conv_start)
		else $error("conversion start not a single pulse");

	conv_clear_a: assert property (conv_done && !wr_ctrl
		|=> !conversion_control[adcsr_pkg::CTL_CONV])
		else $error("conversion bit not cleared at completion");

	self_full_a: assert property (wr_ctrl && wdata[3:0] == 4'h1
		|=> cal_go && cal_steps == 3'h7 && !cal_system)
		else $error("full self calibration decoded wrong");

	sys_offset_a: assert property (wr_ctrl && wdata[3:0] == 4'hD
		|=> cal_go && cal_steps == 3'h1 && cal_system)
		else $error("system offset calibration decoded wrong");

	result_lead_a: assert property (rsel == adcsr_pkg::RD_RESULT
		|=> lk.rd_word[15:14] == 2'h0 && lk.rd_word[13:0] == $past(conv_result))
		else $error("result read lacks leading zeros");

	status_sel_a: assert property (rsel == adcsr_pkg::RD_STATUS
		|=> lk.rd_word[7:6] == 2'h3)
		else $error("status read does not show select bits");

	status_zero_a: assert property (rsel == adcsr_pkg::RD_STATUS
		|=> !lk.rd_word[15] && lk.rd_word[13:10] == 4'h0)
		else $error("status read fixed zeros wrong");

	test_read_a: assert property (rsel == adcsr_pkg::RD_TEST
		|=> lk.rd_word == {2'h0, $past(test_reg)})
		else $error("test read source wrong");

	cal_read_a: assert property (rsel == adcsr_pkg::RD_CAL
		|=> lk.rd_word == {2'h0, $past(cal_rd_data)})
		else $error("calibration read source wrong");

	rsel_hold_a: assert property (!wr_ctrl |=> $stable(rsel))
		else $error("read source changed without a control write");

	cal_clear_a: assert property (cal_done && !wr_ctrl
		|=> !conversion_control[adcsr_pkg::CTL_CALGO])
		else $error("calibration start bit not cleared at its end");

	cal_pulse_a: assert property (wr_ctrl && wdata[adcsr_pkg::CTL_CALGO]
		|=> cal_go ##1 !cal_go)
		else $error("calibration start not a single pulse");

	steps_hold_a: assert property (!(wr_ctrl && wdata[adcsr_pkg::CTL_CALGO])
		|=> $stable(cal_steps) && $stable(cal_system))
		else $error("calibration type changed without a start");

	power_bits_a: assert property (power_state[1:0] ==
		$past(conversion_control[adcsr_pkg::CTL_PD_HI:adcsr_pkg::CTL_PD_LO]))
		else $error("power-down bits not carried to the mode output");

	sleep_pin_a: assert property (power_state[2] == !$past(sleep_s2))
		else $error("sleep pin not carried to the mode output");

	ctrl_cov: cover property (wr_ctrl ##[1:400] lk.read_done);
	cal_cov:  cover property (cal_go ##[1:200] cal_done);
	conv_cov: cover property (conv_start ##[1:200] conv_done);
	rd_cov:   cover property (rsel == adcsr_pkg::RD_STATUS && lk.read_done);

endmodule // adcsr_top

// ==== verification/adcsr_host.sv ====
// host serial controller model: frames 16-bit words on the serial pins
`timescale 1ns/1ps
module adcsr_host
(
	// clock
	input  wire logic core_clk,
	// serial pins
	output logic      sclk,
	output logic      sync_n,
	output logic      din,
	output logic      din_en,
	input  wire logic dout,
	input  wire logic din_line
);
	// idle pins: clock low, frame high
	initial
	begin
		sclk   = 1'b0;
		sync_n = 1'b1;
		din    = 1'b0;
		din_en = 1'b1;
	end

	// one frame of nbits rising edges; rel hands the data line to the device
	// read bits are taken at the end of the high phase, well after the shift
	task automatic frame(input logic [15:0] word, input int nbits, input logic rel,
		output logic [15:0] rd);
		rd = 16'h0000;
		@(negedge core_clk);
		sync_n = 1'b0;
		din_en = !rel;
		repeat (4) @(negedge core_clk);
		for (int i = 15; i > 15 - nbits; i--)
		begin
			din = rel ? !din : word[i];
			repeat (4) @(negedge core_clk);
			sclk = 1'b1;
			repeat (4) @(negedge core_clk);
			rd[i] = rel ? din_line : dout;
			sclk = 1'b0;
		end
		repeat (4) @(negedge core_clk);
		sync_n = 1'b1;
		din    = !din; // a stale bit must not look valid
		repeat (8) @(negedge core_clk);
		din_en = 1'b1; // take the line back only once the device has let go
	endtask
endmodule // adcsr_host

// ==== verification/adc_serial_register_decode_bench.sv ====
// self-checking bench for the serial register decode block
`timescale 1ns/1ps
module adc_serial_register_decode_bench;
	typedef struct packed {logic [15:0] word; logic [2:0] steps;} adcsr_row_type;

	logic        core_clk, resetn, sclk, sync_n, host_din, host_en, din_line;
	logic        dout, din_out, din_oe, sleep_n, conv_done, cal_done;
	logic [13:0] conv_result, cal_rd_data, cal_wr_data;
	logic        conv_start, cal_go, cal_system, cal_wr_en, serial_mode1;
	logic [2:0]  cal_steps, power_state;
	logic [1:0]  cal_sel;
	logic [15:0] rd;
	int          mismatches, compares, cycles, n_conv, n_cal, n_cwr, n_oe, n_clash, c0;

	// calibration start words (host keeps bits 13:10 zero)
	adcsr_row_type rows [8] = '{'{16'hC0C1, 3'h7}, '{16'hC0C3, 3'h3}, '{16'hC0C5, 3'h1},
		'{16'hC0C7, 3'h2}, '{16'hC0C9, 3'h7}, '{16'hC0CB, 3'h3}, '{16'hC0CD, 3'h1},
		'{16'hC0CF, 3'h2}};

	// wired data pin: the device wins while it drives
	assign din_line = din_oe ? din_out : host_din;

	adcsr_top dut (.core_clk(core_clk), .resetn(resetn), .sclk(sclk), .sync_n(sync_n),
		.din(din_line), .dout(dout), .din_out(din_out), .din_oe(din_oe),
		.sleep_n(sleep_n), .conv_done(conv_done), .cal_done(cal_done),
		.conv_result(conv_result), .cal_rd_data(cal_rd_data), .conv_start(conv_start),
		.cal_go(cal_go), .cal_system(cal_system), .cal_steps(cal_steps),
		.cal_sel(cal_sel), .cal_wr_en(cal_wr_en), .cal_wr_data(cal_wr_data),
		.power_state(power_state), .serial_mode1(serial_mode1));

	adcsr_host host (.core_clk(core_clk), .sclk(sclk), .sync_n(sync_n), .din(host_din),
		.din_en(host_en), .dout(dout), .din_line(din_line));

	// 40 MHz core clock
	initial
	begin
		core_clk = 1'b0;
		forever #12.5 core_clk = !core_clk;
	end

	// pulse counters and the hang limit
	always @(posedge core_clk)
	begin
		cycles++;
		n_conv += (conv_start === 1'b1);
		n_cal  += (cal_go === 1'b1);
		n_cwr  += (cal_wr_en === 1'b1);
		n_oe   += (din_oe === 1'b1);
		n_clash += (din_oe === 1'b1 && host_en === 1'b1);
		if (cycles == 20000)
		begin
			mismatches++;
			close_out();
		end
	end

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task automatic close_out();
		$display("checks %0d, mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [15:0] w);
		host.frame(w, 16, 1'b0, rd);
	endtask

	// a read frame writes address 00, which must be dropped
	task automatic rd_chk(input string what, input logic [15:0] exp);
		host.frame(16'h0000, 16, 1'b0, rd);
		chk(what, rd, exp);
	endtask

	function automatic logic [15:0] status_of(input logic [13:0] c, input logic busy);
		return {1'b0, busy, 4'h0, c[9:5], 1'b0, c[3:0]};
	endfunction

	task automatic pulse_done(input logic cal);
		@(negedge core_clk);
		if (cal) cal_done = 1'b1; else conv_done = 1'b1;
		@(negedge core_clk);
		cal_done  = 1'b0;
		conv_done = 1'b0;
		repeat (2) @(negedge core_clk);
	endtask

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial
	begin
		resetn = 1'b0;
		sleep_n = 1'b1;
		conv_done = 1'b0;
		cal_done = 1'b0;
		conv_result = 14'h3FFF;
		cal_rd_data = 14'h2A5C;
		repeat (2) @(posedge core_clk);
		@(negedge core_clk) resetn = 1'b1;
		repeat (4) @(negedge core_clk);
		chk("cal_sel", 16'(cal_sel), 16'h0000);
		chk("serial_mode1", 16'(serial_mode1), 16'h0000);
		chk("power_state", 16'(power_state), 16'h0000);
		rd_chk("result read", 16'h3FFF);
		// every calibration code: start pulse, steps, status busy then idle
		foreach (rows[r])
		begin
			c0 = n_cal;
			wr(rows[r].word);
			chk("cal_go", 16'(n_cal - c0), 16'h0001);
			chk("cal_steps", 16'(cal_steps), 16'(rows[r].steps));
			chk("cal_system", 16'(cal_system), 16'(rows[r].word[3]));
			rd_chk("status busy", status_of(rows[r].word[13:0], 1'b1));
			pulse_done(1'b1);
			rd_chk("status idle", status_of({rows[r].word[13:1], 1'b0}, 1'b0));
		end
		// test register round trip
		wr(16'h5234);
		wr(16'hC040);
		rd_chk("test read", 16'h1234);
		// calibration coefficient write and read
		c0 = n_cwr;
		wr(16'hAABC);
		chk("cal_wr_en", 16'(n_cwr - c0), 16'h0001);
		chk("cal_wr_data", 16'(cal_wr_data), 16'h2ABC);
		wr(16'hC084);
		chk("cal_sel", 16'(cal_sel), 16'h0002);
		rd_chk("cal read", {2'b00, cal_rd_data});
		rd_chk("cal reread", {2'b00, cal_rd_data});
		// short frame and address 00 leave everything alone
		c0 = n_cwr;
		host.frame(16'hFFFF, 10, 1'b0, rd);
		wr(16'h3FFF);
		chk("cal_sel kept", 16'(cal_sel), 16'h0002);
		chk("power kept", 16'(power_state), 16'h0000);
		chk("no cal write", 16'(n_cwr - c0), 16'h0000);
		// software conversion start, cleared by the engine
		c0 = n_conv;
		wr(16'hC0D0);
		chk("conv_start", 16'(n_conv - c0), 16'h0001);
		rd_chk("conv busy", status_of(14'h00D0, 1'b1));
		pulse_done(1'b0);
		rd_chk("conv idle", status_of(14'h00C0, 1'b0));
		// power-down bits with the sleep pin
		wr(16'hC3C0);
		chk("power_state", 16'(power_state), 16'h0003);
		@(negedge core_clk) sleep_n = 1'b0;
		repeat (6) @(negedge core_clk);
		chk("power_state sleep", 16'(power_state), 16'h0007);
		sleep_n = 1'b1;
		// interface mode 1: read data comes back on the data input pin
		wr(16'hC0E0); // mode bit set in the write
		chk("serial_mode1", 16'(serial_mode1), 16'h0001);
		c0 = n_oe;
		host.frame(16'h0000, 16, 1'b1, rd);
		chk("mode1 read", rd, status_of(14'h00E0, 1'b0));
		chk("din_oe seen", 16'(n_oe != c0), 16'h0001);
		chk("mode bit cleared", 16'(serial_mode1), 16'h0000);
		chk("din clash", 16'(n_clash), 16'h0000);
		// reset in mid-run returns every register to its power-up value
		wr(16'hC3E0);
		@(negedge core_clk) resetn = 1'b0;
		repeat (2) @(negedge core_clk);
		resetn = 1'b1;
		repeat (4) @(negedge core_clk);
		chk("power after reset", 16'(power_state), 16'h0000);
		chk("mode after reset", 16'(serial_mode1), 16'h0000);
		rd_chk("read after reset", 16'h3FFF);
		close_out();
	end
endmodule // adc_serial_register_decode_bench
